// *** mstat_pkg.sv ***
// Package with the register map, field layout and carrier types of the modem status block.
package mstat_pkg;

    // Register byte addresses on the Avalon-MM slave.
    localparam logic [4:0] MSTAT_STATUS_OFS = 5'h00;
    localparam logic [4:0] MSTAT_CTRL_OFS = 5'h04;
    localparam logic [4:0] MSTAT_IRQ_STAT_OFS = 5'h08;
    localparam logic [4:0] MSTAT_IRQ_CLR_OFS = 5'h0C;
    localparam logic [4:0] MSTAT_IRQ_EN_OFS = 5'h10;

    // Status byte bit positions.
    localparam int MSTAT_CARRIER_BIT = 0;
    localparam int MSTAT_UNUSED_BIT = 1;
    localparam int MSTAT_CTS_BIT = 2;
    localparam int MSTAT_READY_BIT = 3;
    localparam int MSTAT_HDX_BIT = 4;
    localparam int MSTAT_RTS_BIT = 5;
    localparam int MSTAT_DTR_BIT = 6;
    localparam int MSTAT_RING_BIT = 7;

    // Control register bit positions.
    localparam int MSTAT_CTL_RTS_BIT = 0;
    localparam int MSTAT_CTL_DTR_BIT = 1;
    localparam int MSTAT_CTL_HDX_BIT = 2;

    // Event bit positions in the interrupt status, clear and enable registers.
    localparam int MSTAT_EV_CARRIER = 0;
    localparam int MSTAT_EV_CTS_ON = 1;
    localparam int MSTAT_EV_CTS_OFF = 2;
    localparam int MSTAT_EV_READY_LOST = 3;
    localparam int MSTAT_EV_RING = 4;
    localparam int MSTAT_EV_W = 5;

    // Values after reset.
    localparam logic [2:0] MSTAT_CTRL_RST = 3'h0;
    localparam logic [4:0] MSTAT_EV_RST = 5'h00;
    localparam logic [31:0] MSTAT_RDATA_RST = 32'h0000_0000;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } mstat_avs_req_t;

    // Modem interface levels driven by the local modem.
    typedef struct packed {
        logic carrier;
        logic cts;
        logic ready;
        logic ring;
    } mstat_modem_in_t;

    // Turn-around handshake states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        MSTAT_HS_IDLE = 2'b00,
        MSTAT_HS_WAIT_CTS = 2'b01,
        MSTAT_HS_SEND = 2'b11,
        MSTAT_HS_DRAIN = 2'b10
    } mstat_hs_t;

endpackage

// *** mstat_top.sv ***
// Modem status register block with modem control outputs and interrupts.
`timescale 1ns/1ps

module mstat_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input mstat_pkg::mstat_avs_req_t avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input mstat_pkg::mstat_modem_in_t modem_i,
    output logic rts_o,
    output logic dtr_o,
    output logic half_duplex_o,
    output logic tx_permit_o,
    output logic irq_o
);

    // Synchroniser stages; stage one feeds stage two only.
    mstat_pkg::mstat_modem_in_t sync1_r;
    mstat_pkg::mstat_modem_in_t sync2_r;
    mstat_pkg::mstat_modem_in_t prev_r;
    logic [2:0] ctrl_r;
    logic [2:0] ctrl_nxt;
    logic [4:0] ev_stat_r;
    logic [4:0] ev_stat_nxt;
    logic [4:0] ev_en_r;
    logic [4:0] ev_en_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wait_r;
    logic wait_nxt;
    logic irq_r;
    logic permit_r;
    mstat_pkg::mstat_hs_t hs_r;
    mstat_pkg::mstat_hs_t hs_nxt;

    // Bus decode: a request is taken at the edge where waitrequest is already low.
    wire req_w = avs_req_i.read | avs_req_i.write;
    wire take_w = req_w & ~wait_r;
    wire wr_w = take_w & avs_req_i.write & avs_req_i.byteenable[0];
    wire sel_status_w = avs_req_i.address == mstat_pkg::MSTAT_STATUS_OFS;
    wire sel_ctrl_w = avs_req_i.address == mstat_pkg::MSTAT_CTRL_OFS;
    wire sel_istat_w = avs_req_i.address == mstat_pkg::MSTAT_IRQ_STAT_OFS;
    wire sel_iclr_w = avs_req_i.address == mstat_pkg::MSTAT_IRQ_CLR_OFS;
    wire sel_ien_w = avs_req_i.address == mstat_pkg::MSTAT_IRQ_EN_OFS;
    wire [4:0] wbits_w = avs_req_i.writedata[4:0];

    // Status byte assembled from synchronised levels and control bits.
    wire [7:0] status_w;
    assign status_w[mstat_pkg::MSTAT_CARRIER_BIT] = sync2_r.carrier;
    assign status_w[mstat_pkg::MSTAT_UNUSED_BIT] = 1'b0;
    assign status_w[mstat_pkg::MSTAT_CTS_BIT] = sync2_r.cts;
    assign status_w[mstat_pkg::MSTAT_READY_BIT] = sync2_r.ready;
    assign status_w[mstat_pkg::MSTAT_HDX_BIT] = ctrl_r[mstat_pkg::MSTAT_CTL_HDX_BIT];
    assign status_w[mstat_pkg::MSTAT_RTS_BIT] = ctrl_r[mstat_pkg::MSTAT_CTL_RTS_BIT];
    assign status_w[mstat_pkg::MSTAT_DTR_BIT] = ctrl_r[mstat_pkg::MSTAT_CTL_DTR_BIT];
    // Ring is passed straight through, never gated by the terminal-ready bit.
    assign status_w[mstat_pkg::MSTAT_RING_BIT] = sync2_r.ring;

    // Events derived from the synchronised levels against the prior sample.
    wire [4:0] ev_set_w;
    assign ev_set_w[mstat_pkg::MSTAT_EV_CARRIER] = sync2_r.carrier ^ prev_r.carrier;
    assign ev_set_w[mstat_pkg::MSTAT_EV_CTS_ON] = sync2_r.cts & ~prev_r.cts;
    assign ev_set_w[mstat_pkg::MSTAT_EV_CTS_OFF] = ~sync2_r.cts & prev_r.cts;
    assign ev_set_w[mstat_pkg::MSTAT_EV_READY_LOST] = ~sync2_r.ready & prev_r.ready;
    assign ev_set_w[mstat_pkg::MSTAT_EV_RING] = sync2_r.ring & ~prev_r.ring;

    // Read mux; unmapped and write-only addresses read as zero. Reads change nothing.
    wire [31:0] rmux_w =
        sel_status_w ? {24'h000000, status_w} :
        sel_ctrl_w ? {29'h0000000, ctrl_r} :
        sel_istat_w ? {27'h0000000, ev_stat_r} :
        sel_ien_w ? {27'h0000000, ev_en_r} : 32'h0000_0000;

    // One wait state: the answer is prepared at the first edge and taken at the second.
    assign wait_nxt = ~(req_w & wait_r);
    assign rdata_nxt = (req_w & wait_r & avs_req_i.read) ? rmux_w : rdata_r;

    // Control writes; RTS, DTR and duplex mode steer the modem pins.
    assign ctrl_nxt = (wr_w & sel_ctrl_w) ? avs_req_i.writedata[2:0] : ctrl_r;
    assign ev_en_nxt = (wr_w & sel_ien_w) ? wbits_w : ev_en_r;

    // Sticky events: a set in the clear cycle wins, so no event is lost.
    wire [4:0] clr_w = (wr_w & sel_iclr_w) ? wbits_w : 5'h00;
    assign ev_stat_nxt = (ev_stat_r & ~clr_w) | ev_set_w;

    // Turn-around handshake: data may move only once clear to send answers request to send.
    wire rts_w = ctrl_r[mstat_pkg::MSTAT_CTL_RTS_BIT];
    always_comb
    begin
        hs_nxt = hs_r;
        case (hs_r)
            mstat_pkg::MSTAT_HS_IDLE:
            begin
                if (rts_w)
                    hs_nxt = mstat_pkg::MSTAT_HS_WAIT_CTS;
            end
            mstat_pkg::MSTAT_HS_WAIT_CTS:
            begin
                if (!rts_w)
                    hs_nxt = mstat_pkg::MSTAT_HS_DRAIN;
                else if (sync2_r.cts)
                    hs_nxt = mstat_pkg::MSTAT_HS_SEND;
            end
            mstat_pkg::MSTAT_HS_SEND:
            begin
                if (!rts_w)
                    hs_nxt = mstat_pkg::MSTAT_HS_DRAIN;
            end
            mstat_pkg::MSTAT_HS_DRAIN:
            begin
                // A new request waits until the modem has dropped clear to send.
                if (!sync2_r.cts)
                    hs_nxt = mstat_pkg::MSTAT_HS_IDLE;
            end
            default:
            begin
                hs_nxt = mstat_pkg::MSTAT_HS_IDLE;
            end
        endcase
    end

    wire permit_nxt = (hs_nxt == mstat_pkg::MSTAT_HS_SEND);

    // Two-flop synchroniser and the edge reference stage.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            sync1_r <= modem_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // Bus slave registers.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wait_r <= 1'b1;
            rdata_r <= mstat_pkg::MSTAT_RDATA_RST;
        end
        else
        begin
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Control, interrupt and handshake state.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_r <= mstat_pkg::MSTAT_CTRL_RST;
            ev_stat_r <= mstat_pkg::MSTAT_EV_RST;
            ev_en_r <= mstat_pkg::MSTAT_EV_RST;
            irq_r <= 1'b0;
            hs_r <= mstat_pkg::MSTAT_HS_IDLE;
            permit_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            ev_stat_r <= ev_stat_nxt;
            ev_en_r <= ev_en_nxt;
            irq_r <= |(ev_stat_nxt & ev_en_nxt);
            hs_r <= hs_nxt;
            permit_r <= permit_nxt;
        end
    end

    // Outputs come straight from flops.
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign rts_o = ctrl_r[mstat_pkg::MSTAT_CTL_RTS_BIT];
    assign dtr_o = ctrl_r[mstat_pkg::MSTAT_CTL_DTR_BIT];
    assign half_duplex_o = ctrl_r[mstat_pkg::MSTAT_CTL_HDX_BIT];
    assign tx_permit_o = permit_r;
    assign irq_o = irq_r;

    // Checks on the status byte and the handshake.
    sequence rts_rise_s;
        $rose(rts_o);
    endsequence

    sequence cts_seen_s;
        sync2_r.cts && hs_r == mstat_pkg::MSTAT_HS_WAIT_CTS && rts_o;
    endsequence

    status_carrier_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        modem_i.carrier ##2 1 |-> status_w[0] == $past(modem_i.carrier, 2))
        else $error("Carrier bit does not follow the input after two flops.");

    unused_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        avs_req_i.read && sel_status_w && wait_r |=> avs_readdata_o[1] == 1'b0)
        else $error("Unused status bit read as one.");

    status_cts_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##2 status_w[2] == $past(modem_i.cts, 2))
        else $error("Clear-to-send bit does not follow the input.");

    ready_lost_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(sync2_r.ready) |=> ev_stat_r[mstat_pkg::MSTAT_EV_READY_LOST])
        else $error("Loss of modem ready was not flagged.");

    duplex_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_w && sel_ctrl_w |=> half_duplex_o == $past(avs_req_i.writedata[2]))
        else $error("Duplex mode did not take the written value.");

    rts_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        status_w[5] == rts_o && status_w[6] == dtr_o && status_w[4] == half_duplex_o)
        else $error("Status byte disagrees with the control pins.");

    no_early_tx_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rts_rise_s |-> !tx_permit_o [*2])
        else $error("Transmit permitted before clear to send.");

    permit_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cts_seen_s |=> tx_permit_o)
        else $error("Transmit not permitted one cycle after clear to send.");

    drain_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hs_r == mstat_pkg::MSTAT_HS_DRAIN && sync2_r.cts |=> hs_r != mstat_pkg::MSTAT_HS_SEND
        && !tx_permit_o)
        else $error("New transmit started before clear to send dropped.");

    dtr_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_w && sel_ctrl_w |=> dtr_o == $past(avs_req_i.writedata[1]))
        else $error("Terminal ready did not take the written value.");

    ring_free_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##2 status_w[7] == $past(modem_i.ring, 2))
        else $error("Ring bit does not follow the ring input.");

    read_clean_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take_w && avs_req_i.read && !$rose(sync2_r.ring) && !$fell(sync2_r.ready)
        && sync2_r == prev_r |=> ev_stat_r == $past(ev_stat_r) && ctrl_r == $past(ctrl_r))
        else $error("A read changed block state.");

    bus_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        req_w && wait_r |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("Bus answer not given after one wait state.");

    // Checks on the register bus: one wait state, held read data, refused writes.
    sequence status_read_s;
        avs_req_i.read && sel_status_w && wait_r;
    endsequence

    sequence ctrl_read_s;
        avs_req_i.read && sel_ctrl_w && wait_r;
    endsequence

    status_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        status_read_s |=> avs_readdata_o == {24'h000000, $past(status_w)})
        else $error("Status read returned a stale or wrong byte.");

    ctrl_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ctrl_read_s |=> avs_readdata_o == {29'h0000000, $past(ctrl_r)})
        else $error("Control read returned a wrong value.");

    clr_reads_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        avs_req_i.read && sel_iclr_w && wait_r |=> avs_readdata_o == 32'h0000_0000)
        else $error("Write-only clear register did not read as zero.");

    // Read data stands until the next read is answered, so software may sample it late.
    rdata_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(avs_req_i.read && wait_r) |=> $stable(avs_readdata_o))
        else $error("Read data changed without a read.");

    wait_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("Waitrequest stayed low for more than one cycle.");

    write_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take_w && avs_req_i.write && !avs_req_i.byteenable[0]
        |=> $stable(ctrl_r) && $stable(ev_en_r))
        else $error("A write with its low byte disabled changed a register.");

    rts_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_w && sel_ctrl_w |=> rts_o == $past(avs_req_i.writedata[0]))
        else $error("Request to send did not take the written value.");

    permit_drop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rts_o |=> !tx_permit_o)
        else $error("Transmit still permitted after request to send dropped.");

    status_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##2 status_w[3] == $past(modem_i.ready, 2))
        else $error("Modem ready bit does not follow the input.");

    // Checks on events and the interrupt; a lost event would hide a modem fault.
    carrier_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $changed(sync2_r.carrier) |=> ev_stat_r[mstat_pkg::MSTAT_EV_CARRIER])
        else $error("Carrier change was not flagged.");

    cts_on_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(sync2_r.cts) |=> ev_stat_r[mstat_pkg::MSTAT_EV_CTS_ON])
        else $error("Clear to send rising was not flagged.");

    cts_off_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(sync2_r.cts) |=> ev_stat_r[mstat_pkg::MSTAT_EV_CTS_OFF])
        else $error("Clear to send falling was not flagged.");

    ring_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(sync2_r.ring) |=> ev_stat_r[mstat_pkg::MSTAT_EV_RING])
        else $error("Ring rising was not flagged.");

    sticky_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (|ev_set_w) |=> (ev_stat_r & $past(ev_set_w)) == $past(ev_set_w))
        else $error("An event was lost to a clear in the same cycle.");

    clear_works_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_w && sel_iclr_w |=> (ev_stat_r & $past(clr_w) & ~$past(ev_set_w)) == 5'h00)
        else $error("Written clear bits did not clear their events.");

    enable_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_w && sel_ien_w |=> ev_en_r == $past(wbits_w))
        else $error("Interrupt enable did not take the written value.");

    irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        irq_o == |(ev_stat_r & ev_en_r))
        else $error("Interrupt output disagrees with enabled status bits.");

endmodule // mstat_top

// *** mstat_modem_model.sv ***
// Behavioural model of the local modem that faces the modem status block.
`timescale 1ns/1ps

module mstat_modem_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rts_i,
    input wire logic dtr_i,
    input wire logic carrier_i,
    input wire logic ready_i,
    input wire logic ringing_i,
    input wire logic [3:0] delay_i,
    output mstat_pkg::mstat_modem_in_t modem_o
);
    logic [3:0] cnt_r;
    logic cts_r;
    logic online_r;

    // Clear to send follows request to send only after delay_i + 1 cycles of turn-around.
    // That holds off the answer on a rise and drains pending data on a fall.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= 4'h0;
            cts_r <= 1'b0;
        end
        else if (rts_i != cts_r)
        begin
            cnt_r <= (cnt_r >= delay_i) ? 4'h0 : cnt_r + 4'h1;
            cts_r <= (cnt_r >= delay_i) ? rts_i : cts_r;
        end
        else
        begin
            cnt_r <= 4'h0;
        end
    end

    // The line is held while terminal ready is on and left only once sending has drained.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            online_r <= 1'b0;
        else
            online_r <= dtr_i | (online_r & cts_r);
    end

    // Ring follows the ringing bursts and stays off otherwise, whatever terminal ready does.
    assign modem_o.carrier = carrier_i;
    assign modem_o.cts = cts_r;
    assign modem_o.ready = ready_i & online_r;
    assign modem_o.ring = ringing_i;
endmodule // mstat_modem_model

// *** test_modem_status_register.sv ***
// Self-checking testbench of the modem status block with a modem model at its far side.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end

module test_modem_status_register;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    mstat_pkg::mstat_avs_req_t req = '0;
    mstat_pkg::mstat_modem_in_t modem;
    logic [31:0] rdata;
    logic wreq, rts, dtr, hdx, txp, irq;
    logic car = 1'b0, rdy = 1'b0, rng = 1'b0, onl = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [31:0] seed = 32'hA9702813;
    logic [31:0] q;
    logic [2:0] c;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;

    mstat_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .modem_i(modem), .rts_o(rts), .dtr_o(dtr),
        .half_duplex_o(hdx), .tx_permit_o(txp), .irq_o(irq));
    mstat_modem_model modem_m (.clk_i(clk_i), .rst_n_i(rst_n_i), .rts_i(rts), .dtr_i(dtr),
        .carrier_i(car), .ready_i(rdy), .ringing_i(rng), .delay_i(dly), .modem_o(modem));

    // Free-running 250 MHz clock.
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end

    // Ends a hung run; the whole sequence needs well under this many cycles.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            give_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Status byte expected once the turn-around has settled, so clear to send equals rts.
    // The ready argument is the modem's ready level, already gated by its line state.
    function automatic logic [31:0] exp_stat(input logic [2:0] k, input logic cr, input logic rd,
        input logic rg);
        return {24'h0, rg, k[1], k[0], k[2], rd, k[0], 1'b0, cr};
    endfunction

    // One Avalon transfer held until waitrequest is sampled low; read data lands in q.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge clk_i);
        req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
        do @(posedge clk_i); while (wreq !== 1'b0);
        q = rdata;
        req <= '0;
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence: reset values, random control and levels, handshake, interrupts.
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, 5'(i * 4), 32'h0, 4'hF);
            `CHK(q, 32'h0)
        end
        $display("test reset values done");
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            // The modem holds the line while terminal ready is on or clear to send never dropped.
            onl = seed[1] | (onl & seed[0] & c[0]);
            c = seed[2:0];
            car <= seed[3];
            rdy <= seed[4];
            rng <= seed[5];
            dly <= seed[9:6];
            bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, {29'h0, c}, 4'hF);
            repeat (24) @(posedge clk_i);
            bus(1'b0, mstat_pkg::MSTAT_STATUS_OFS, 32'h0, 4'hF);
            `CHK(q, exp_stat(c, car, rdy & onl, rng))
            `CHK({rts, dtr, hdx, txp}, {c[0], c[1], c[2], c[0]})
        end
        bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, {29'h0, ~c}, 4'h0);
        bus(1'b0, mstat_pkg::MSTAT_CTRL_OFS, 32'h0, 4'hF);
        `CHK(q, {29'h0, c})
        $display("test random levels done");
        bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, 32'h0, 4'hF);
        dly <= 4'hF;
        repeat (24) @(posedge clk_i);
        bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, 32'h1, 4'hF);
        for (int n = 0; n < 40 && txp !== 1'b1; n++)
        begin
            @(posedge clk_i);
            `CHK(txp & !modem.cts, 1'b0)
        end
        `CHK(txp, 1'b1)
        bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, 32'h0, 4'hF);
        repeat (2) @(posedge clk_i);
        `CHK(txp, 1'b0)
        $display("test handshake done");
        rng <= 1'b0;
        repeat (24) @(posedge clk_i);
        bus(1'b1, mstat_pkg::MSTAT_IRQ_CLR_OFS, 32'h1F, 4'hF);
        bus(1'b1, mstat_pkg::MSTAT_IRQ_EN_OFS, 32'h10, 4'hF);
        rng <= 1'b1;
        repeat (5) @(posedge clk_i);
        `CHK(irq, 1'b1)
        bus(1'b0, mstat_pkg::MSTAT_IRQ_STAT_OFS, 32'h0, 4'hF);
        `CHK(q, 32'h10)
        bus(1'b1, mstat_pkg::MSTAT_IRQ_CLR_OFS, 32'h10, 4'hF);
        car <= ~car;
        repeat (5) @(posedge clk_i);
        `CHK(irq, 1'b0)
        bus(1'b0, mstat_pkg::MSTAT_IRQ_STAT_OFS, 32'h0, 4'hF);
        `CHK(q, 32'h01)
        bus(1'b1, mstat_pkg::MSTAT_IRQ_EN_OFS, 32'h01, 4'hF);
        repeat (3) @(posedge clk_i);
        `CHK(irq, 1'b1)
        bus(1'b1, mstat_pkg::MSTAT_IRQ_CLR_OFS, 32'h1F, 4'hF);
        rdy <= 1'b1;
        bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, 32'h3, 4'hF);
        repeat (40) @(posedge clk_i);
        bus(1'b0, mstat_pkg::MSTAT_IRQ_STAT_OFS, 32'h0, 4'hF);
        `CHK(q, 32'h02)
        bus(1'b1, mstat_pkg::MSTAT_CTRL_OFS, 32'h0, 4'hF);
        repeat (40) @(posedge clk_i);
        bus(1'b0, mstat_pkg::MSTAT_IRQ_STAT_OFS, 32'h0, 4'hF);
        `CHK(q, 32'h0E)
        $display("test interrupts done");
        give_verdict();
    end
endmodule // test_modem_status_register
